// file: rtl/uifc_consts.vh
// Constants for the serial controller with infrared and flow control.
// Included by every design file; holds definitions only.
`ifndef UIFC_CONSTS_VH
`define UIFC_CONSTS_VH
`define UIFC_FIFO_DEPTH 15
`define UIFC_PTR_W 4
`define UIFC_OVS 16
`define UIFC_IR_PULSE 3
`define UIFC_MODE_UART 2'h0
`define UIFC_MODE_IR 2'h2
`define UIFC_IR_INV_RST 1'b1
`define UIFC_IR_INV_BIT 6
`define UIFC_RX_TOUT_W 7
`define UIFC_LEN_5 2'h0
`define UIFC_PAR_EVEN_BIT 1
`define UIFC_PAR_STICK_BIT 2
`endif

// file: rtl/uifc_fifo.v
// Fifteen-entry flip-flop FIFO used for both transmit and receive paths.
// Assumes one clock; writes into a full FIFO are dropped inside the FIFO.
`timescale 1ns/1ps
`include "uifc_consts.vh"
module uifc_fifo #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Write side
  input wire wr_in,
  input wire [WIDTH-1:0] wdata_in,
  // Read side
  input wire rd_in,
  output wire [WIDTH-1:0] rdata_out,
  // Status
  output wire [`UIFC_PTR_W-1:0] count_out,
  output wire full_out,
  output wire empty_out
);
  reg [WIDTH-1:0] mem_reg [0:`UIFC_FIFO_DEPTH-1];
  reg [`UIFC_PTR_W-1:0] wp_reg;
  reg [`UIFC_PTR_W-1:0] rp_reg;
  reg [`UIFC_PTR_W-1:0] cnt_reg;
  wire do_wr;
  wire do_rd;

  // Wrap an index at the depth, not at a power of two
  function [`UIFC_PTR_W-1:0] uifc_inc;
    input [`UIFC_PTR_W-1:0] p;
    begin
      uifc_inc = (p == `UIFC_FIFO_DEPTH - 1) ? {`UIFC_PTR_W{1'b0}} : p + 1'b1;
    end
  endfunction

  assign full_out = (cnt_reg == `UIFC_FIFO_DEPTH);
  assign empty_out = (cnt_reg == {`UIFC_PTR_W{1'b0}});
  assign count_out = cnt_reg;
  assign rdata_out = mem_reg[rp_reg];
  assign do_wr = wr_in & ~full_out;
  assign do_rd = rd_in & ~empty_out;

  // Storage array needs no reset
  always @(posedge ref_clk_in)
  begin
    if (do_wr)
      mem_reg[wp_reg] <= wdata_in;
  end

  // Pointers and fill count
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wp_reg <= {`UIFC_PTR_W{1'b0}};
      rp_reg <= {`UIFC_PTR_W{1'b0}};
      cnt_reg <= {`UIFC_PTR_W{1'b0}};
    end
    else
    begin
      if (do_wr)
        wp_reg <= uifc_inc(wp_reg);
      if (do_rd)
        rp_reg <= uifc_inc(rp_reg);
      if (do_wr & ~do_rd)
        cnt_reg <= cnt_reg + 1'b1;
      else if (do_rd & ~do_wr)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule

// file: rtl/uifc_baud.v
// Baud tick generator: emits one tick per oversample slot (16 per bit,
// B+1 per bit in divider mode 1, one per bit in divider mode 2).
// Assumes software keeps the divisors within their documented minimums.
`timescale 1ns/1ps
`include "uifc_consts.vh"
module uifc_baud (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Configuration
  input wire [15:0] baud_divisor_value_in,
  input wire [3:0] div_x_in,
  input wire div_x_en_in,
  input wire div_x_one_in,
  input wire ir_mode_in,
  // Ticks
  output reg tick_out,
  output reg bit_mode_out
);
  reg [16:0] cnt_reg;
  reg [16:0] limit;

  // Mode 0: 16*(A+2); mode 1: (B+1)*(A+2) as (A+2) per tick, B+1 ticks/bit;
  // mode 2: A+2 per bit; infrared: 16*A
  always @*
  begin
    if (ir_mode_in)
      limit = {1'b0, baud_divisor_value_in} - 17'h0_0001;
    else
      limit = {1'b0, baud_divisor_value_in} + 17'h0_0001;
  end

  // Divide kernel clock down to the slot rate
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg <= 17'h0_0000;
      tick_out <= 1'b0;
      bit_mode_out <= 1'b0;
    end
    else
    begin
      bit_mode_out <= div_x_en_in & ~ir_mode_in;
      if (cnt_reg >= limit)
      begin
        cnt_reg <= 17'h0_0000;
        tick_out <= 1'b1;
      end
      else
      begin
        cnt_reg <= cnt_reg + 17'h0_0001;
        tick_out <= 1'b0;
      end
    end
  end
endmodule

// file: rtl/uifc_top.v
// Serial controller core: TX and RX FIFOs, character engines, flow control,
// infrared encoder/decoder and interrupt source flags.
// Assumes register logic outside drives the configuration ports statically.
`timescale 1ns/1ps
`include "uifc_consts.vh"
// Operation
// - Separate interrupt sources for six event kinds
// - Fifteen-byte transmit FIFO before shifter
// - Fifteen-entry receive FIFO with three error flags
// - Mode 0 baud: clock over 16*(divisor+2)
// - Mode 1 baud: (X+1)*(divisor+2); X at least eight
// - Mode 2 baud: divisor+2; divisor at least three
// - Request-to-send drops at RTS deassert FIFO level
// - Transmit only while clear-to-send asserted
// - Infrared frame: start, eight data, stop
// - Infrared is half duplex
// - Infrared baud: clock over 16*divisor
// - Encoder sends zero as 3/16 pulse
// - Decoder idles high, start on low
// - Infrared control bit six resets to one
// - Character length five to eight bits
// - Parity even, odd, none, stick, both directions
// - One, one and half, or two stops
// - Seven-bit receive idle timeout
// - Programmable gap between characters
// - Shift least significant bit first
module uifc_top (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Transmit data in
  input wire tx_wr_in,
  input wire [7:0] tx_data_in,
  // Receive data out
  input wire rx_rd_in,
  output reg [7:0] rx_data_out,
  output reg [2:0] rx_err_out,
  output reg rx_empty_out,
  output reg tx_full_out,
  // Line configuration
  input wire [1:0] char_len_in,
  input wire two_stop_in,
  input wire parity_en_in,
  input wire [2:0] parity_cfg_in,
  input wire [15:0] baud_divisor_value_in,
  input wire [3:0] div_x_in,
  input wire div_x_en_in,
  input wire div_x_one_in,
  input wire [1:0] function_select_in,
  input wire [7:0] infrared_control_in,
  input wire infrared_control_wr_in,
  input wire [3:0] rx_trigger_level_in,
  input wire [3:0] rts_deassert_fifo_level_in,
  input wire auto_rts_en_in,
  input wire auto_cts_en_in,
  input wire [6:0] rx_timeout_count_in,
  input wire [7:0] tx_gap_delay_in,
  // Status clears
  input wire line_err_clr_in,
  input wire modem_clr_in,
  input wire buf_err_clr_in,
  // Interrupt sources
  output reg tx_empty_interrupt_out,
  output reg rx_threshold_interrupt_out,
  output reg line_error_interrupt_out,
  output reg rx_idle_timeout_interrupt_out,
  output reg modem_interrupt_out,
  output reg buf_err_interrupt_out,
  output reg [7:0] infrared_control_out,
  // Serial pins
  input wire rxd_in,
  input wire cts_n_in,
  output reg txd_out,
  output reg rts_n_out
);
  // Transmit states
  localparam TX_IDLE = 3'h0;
  localparam TX_START = 3'h1;
  localparam TX_DATA = 3'h2;
  localparam TX_PAR = 3'h3;
  localparam TX_STOP = 3'h4;
  localparam TX_GAP = 3'h5;

  wire tick;
  wire bit_mode;
  wire ir_mode = (function_select_in == `UIFC_MODE_IR);
  wire [7:0] txf_data;
  wire [3:0] txf_cnt;
  wire txf_full;
  wire txf_empty;
  wire [10:0] rxf_data;
  wire [3:0] rxf_cnt;
  wire rxf_full;
  wire rxf_empty;
  reg [1:0] rxd_sync_reg;
  reg [1:0] cts_sync_reg;
  reg [3:0] slot_reg;
  reg [7:0] infrared_control_reg;
  reg [2:0] tx_state_reg;
  reg [7:0] tx_sh_reg;
  reg [2:0] tx_bit_reg;
  reg [4:0] tx_slot_reg;
  reg [7:0] tx_gap_reg;
  reg tx_par_reg;
  reg tx_line_reg;
  reg txf_pop;
  reg [2:0] rx_state_reg;
  reg [3:0] rx_slot_reg;
  reg [2:0] rx_bit_reg;
  reg [7:0] rx_sh_reg;
  reg rx_par_reg;
  reg rx_push;
  reg [10:0] rx_word;
  reg [6:0] rx_idle_reg;
  reg rx_prev_reg;

  // Slots per bit: 16 normally, B+1 in divider mode 1, 1 in mode 2
  wire [4:0] slots_per_bit = !bit_mode ? 5'h10 :
    (div_x_one_in ? 5'h01 : {1'b0, div_x_in} + 5'h01);
  wire [4:0] mid_slot = slots_per_bit >> 1;
  wire [3:0] data_bits = {2'h0, char_len_in} + 4'h5;

  // Parity of a byte for the configured length
  function uifc_parity;
    input [7:0] d;
    input [3:0] n;
    input [2:0] cfg;
    reg p;
    integer i;
    begin
      p = 1'b0;
      for (i = 0; i < 8; i = i + 1)
        if (i < n)
          p = p ^ d[i];
      if (cfg[`UIFC_PAR_STICK_BIT])
        uifc_parity = ~cfg[`UIFC_PAR_EVEN_BIT];
      else
        uifc_parity = cfg[`UIFC_PAR_EVEN_BIT] ? p : ~p;
    end
  endfunction

  // Divider modes 0, 1, 2 and infrared rate
  uifc_baud u_baud (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .baud_divisor_value_in(baud_divisor_value_in),
    .div_x_in(div_x_in),
    .div_x_en_in(div_x_en_in),
    .div_x_one_in(div_x_one_in),
    .ir_mode_in(ir_mode),
    .tick_out(tick),
    .bit_mode_out(bit_mode)
  );

  // Transmit FIFO ahead of shifter
  uifc_fifo #(.WIDTH(8)) u_txf (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(tx_wr_in),
    .wdata_in(tx_data_in),
    .rd_in(txf_pop),
    .rdata_out(txf_data),
    .count_out(txf_cnt),
    .full_out(txf_full),
    .empty_out(txf_empty)
  );

  // Receive FIFO with break, framing, parity flags per entry
  uifc_fifo #(.WIDTH(11)) u_rxf (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .wr_in(rx_push),
    .wdata_in(rx_word),
    .rd_in(rx_rd_in),
    .rdata_out(rxf_data),
    .count_out(rxf_cnt),
    .full_out(rxf_full),
    .empty_out(rxf_empty)
  );

  // Pin synchronisers; the first stage feeds only the second
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rxd_sync_reg <= 2'h3;
      cts_sync_reg <= 2'h3;
    end
    else
    begin
      rxd_sync_reg <= {rxd_sync_reg[0], rxd_in};
      cts_sync_reg <= {cts_sync_reg[0], cts_n_in};
    end
  end

  // Decoder: idle high; any low pulse marks a zero bit
  wire ir_rx_raw = infrared_control_reg[`UIFC_IR_INV_BIT] ? rxd_sync_reg[1] : ~rxd_sync_reg[1];
  reg ir_hold_reg;
  wire rx_line = ir_mode ? (ir_hold_reg & ir_rx_raw) : rxd_sync_reg[1];
  // Half duplex: receiver is blind while transmitting in infrared
  wire rx_line_eff = (ir_mode && tx_state_reg != TX_IDLE) ? 1'b1 : rx_line;
  wire cts_ok = ~auto_cts_en_in | ~cts_sync_reg[1];

  // Infrared control register, bit six resets to one
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      infrared_control_reg <= {1'b0, `UIFC_IR_INV_RST, 6'h00};
    else if (infrared_control_wr_in)
      infrared_control_reg <= infrared_control_in;
  end

  // Transmit engine, LSB first
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_state_reg <= TX_IDLE;
      tx_sh_reg <= 8'h00;
      tx_bit_reg <= 3'h0;
      tx_slot_reg <= 5'h00;
      tx_gap_reg <= 8'h00;
      tx_par_reg <= 1'b0;
      tx_line_reg <= 1'b1;
      txf_pop <= 1'b0;
    end
    else
    begin
      txf_pop <= 1'b0;
      if (tick)
      begin
        tx_slot_reg <= tx_slot_reg + 5'h01;
        case (tx_state_reg)
          TX_IDLE:
          begin
            tx_slot_reg <= 5'h00;
            // Start only with data and clear-to-send held
            // Infrared waits for an idle receiver
            if (!txf_empty && !txf_pop && cts_ok && !(ir_mode && rx_state_reg != 3'h0))
            begin
              tx_sh_reg <= txf_data;
              tx_par_reg <= uifc_parity(txf_data, ir_mode ? 4'h8 : data_bits, parity_cfg_in);
              txf_pop <= 1'b1;
              tx_line_reg <= 1'b0;
              tx_state_reg <= TX_START;
            end
          end
          TX_START, TX_DATA, TX_PAR:
          begin
            if (tx_slot_reg + 5'h01 == slots_per_bit)
            begin
              tx_slot_reg <= 5'h00;
              if (tx_state_reg == TX_START)
              begin
                tx_line_reg <= tx_sh_reg[0];
                tx_bit_reg <= 3'h0;
                tx_state_reg <= TX_DATA;
              end
              else if (tx_state_reg == TX_DATA &&
                       ({1'b0, tx_bit_reg} + 4'h1) < (ir_mode ? 4'h8 : data_bits))
              begin
                // Length five to eight, fixed eight in infrared
                tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
                tx_line_reg <= tx_sh_reg[1];
                tx_bit_reg <= tx_bit_reg + 3'h1;
              end
              else if (tx_state_reg == TX_DATA && parity_en_in && !ir_mode)
              begin
                tx_line_reg <= tx_par_reg;
                tx_state_reg <= TX_PAR;
              end
              else
              begin
                tx_line_reg <= 1'b1;
                tx_state_reg <= TX_STOP;
              end
            end
          end
          TX_STOP:
          begin
            // 1, 1.5 (len 5) or 2 stop bits
            if (tx_slot_reg + 5'h01 == ((!two_stop_in || ir_mode) ? slots_per_bit :
                (char_len_in == `UIFC_LEN_5 ? slots_per_bit + mid_slot : slots_per_bit << 1)))
            begin
              tx_slot_reg <= 5'h00;
              tx_gap_reg <= tx_gap_delay_in;
              tx_state_reg <= TX_GAP;
            end
          end
          TX_GAP:
          begin
            // Idle bit times between characters
            if (tx_slot_reg + 5'h01 == slots_per_bit)
            begin
              tx_slot_reg <= 5'h00;
              if (tx_gap_reg == 8'h00)
                tx_state_reg <= TX_IDLE;
              else
                tx_gap_reg <= tx_gap_reg - 8'h01;
            end
          end
          default: tx_state_reg <= TX_IDLE;
        endcase
      end
    end
  end

  // Receive engine, mid-bit sampling, LSB first
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_state_reg <= 3'h0;
      rx_slot_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      rx_par_reg <= 1'b0;
      rx_push <= 1'b0;
      rx_word <= 11'h000;
      ir_hold_reg <= 1'b1;
    end
    else
    begin
      rx_push <= 1'b0;
      if (tick)
      begin
        // Stretch infrared pulse to a full bit; cleared at bit boundaries
        if (!ir_rx_raw)
          ir_hold_reg <= 1'b0;
        else if (rx_slot_reg == 4'h0)
          ir_hold_reg <= 1'b1;
        rx_slot_reg <= rx_slot_reg + 4'h1;
        case (rx_state_reg)
          3'h0:
          begin
            rx_slot_reg <= 4'h0;
            if (!rx_line_eff)
              rx_state_reg <= 3'h1; // Start on low
          end
          3'h1, 3'h2, 3'h3, 3'h4:
          begin
            if ({1'b0, rx_slot_reg} + 5'h01 == mid_slot || (slots_per_bit == 5'h01))
            begin
              case (rx_state_reg)
                3'h1: rx_state_reg <= rx_line_eff ? 3'h0 : 3'h2;
                3'h2:
                begin
                  rx_sh_reg <= {rx_line_eff, rx_sh_reg[7:1]};
                  rx_bit_reg <= rx_bit_reg + 3'h1;
                  if (({1'b0, rx_bit_reg} + 4'h1) == (ir_mode ? 4'h8 : data_bits))
                    rx_state_reg <= (parity_en_in && !ir_mode) ? 3'h3 : 3'h4;
                end
                3'h3:
                begin
                  rx_par_reg <= rx_line_eff;
                  rx_state_reg <= 3'h4;
                end
                default:
                begin
                  // Align data, flag break, framing, parity
                  rx_word[7:0] <= rx_sh_reg >> (4'h8 - (ir_mode ? 4'h8 : data_bits));
                  rx_word[10] <= ~rx_line_eff && rx_sh_reg == 8'h00;
                  rx_word[9] <= ~rx_line_eff;
                  rx_word[8] <= parity_en_in && !ir_mode && rx_par_reg !=
                    uifc_parity(rx_sh_reg >> (4'h8 - data_bits), data_bits, parity_cfg_in);
                  rx_push <= 1'b1;
                  rx_bit_reg <= 3'h0;
                  rx_state_reg <= 3'h0;
                end
              endcase
            end
            if ({1'b0, rx_slot_reg} + 5'h01 >= slots_per_bit)
              rx_slot_reg <= 4'h0;
          end
          default: rx_state_reg <= 3'h0;
        endcase
      end
    end
  end

  // Interrupt flags, serial pins and status outputs
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_empty_interrupt_out <= 1'b0;
      rx_threshold_interrupt_out <= 1'b0;
      line_error_interrupt_out <= 1'b0;
      rx_idle_timeout_interrupt_out <= 1'b0;
      modem_interrupt_out <= 1'b0;
      buf_err_interrupt_out <= 1'b0;
      rx_idle_reg <= 7'h00;
      rx_prev_reg <= 1'b1;
      txd_out <= 1'b1;
      rts_n_out <= 1'b1;
      rx_data_out <= 8'h00;
      rx_err_out <= 3'h0;
      rx_empty_out <= 1'b1;
      tx_full_out <= 1'b0;
      slot_reg <= 4'h0;
      infrared_control_out <= {1'b0, `UIFC_IR_INV_RST, 6'h00};
    end
    else
    begin
      // Six separate interrupt sources
      tx_empty_interrupt_out <= txf_empty;
      rx_threshold_interrupt_out <= (rxf_cnt >= rx_trigger_level_in) && !rxf_empty;
      // Sticky flags: a set in the clearing cycle wins
      line_error_interrupt_out <= (rx_push && rx_word[10:8] != 3'h0) ||
                                  (line_err_clr_in ? 1'b0 : line_error_interrupt_out);
      rx_prev_reg <= cts_sync_reg[1];
      modem_interrupt_out <= (rx_prev_reg != cts_sync_reg[1]) ||
                             (modem_clr_in ? 1'b0 : modem_interrupt_out);
      // Overflow: the FIFO drops the push
      buf_err_interrupt_out <= (rx_push && rxf_full) ||
                               (buf_err_clr_in ? 1'b0 : buf_err_interrupt_out);
      // Idle timeout in bit times while data waits
      if (rxf_empty || rx_push || rx_rd_in || rx_state_reg != 3'h0)
      begin
        rx_idle_reg <= 7'h00;
        rx_idle_timeout_interrupt_out <= 1'b0;
      end
      else if (tick && {1'b0, slot_reg} + 5'h01 >= slots_per_bit)
      begin
        if (rx_idle_reg >= rx_timeout_count_in)
          rx_idle_timeout_interrupt_out <= 1'b1;
        else
          rx_idle_reg <= rx_idle_reg + 7'h01;
      end
      if (tick)
        slot_reg <= ({1'b0, slot_reg} + 5'h01 >= slots_per_bit) ? 4'h0 : slot_reg + 4'h1;
      // Encoder: zero sent as 3/16 pulse, active-high light
      if (ir_mode)
        txd_out <= ~tx_line_reg && (tx_slot_reg < `UIFC_IR_PULSE);
      else
        txd_out <= tx_line_reg;
      // Request-to-send low until FIFO hits level
      rts_n_out <= auto_rts_en_in ? (rxf_cnt >= rts_deassert_fifo_level_in) : 1'b0;
      rx_data_out <= rxf_data[7:0];
      rx_err_out <= rxf_data[10:8];
      rx_empty_out <= rxf_empty;
      tx_full_out <= txf_full;
      infrared_control_out <= infrared_control_reg;
    end
  end
endmodule

// file: verif/uifc_checker_assertions.sv
// Checker for the serial controller core, bound onto uifc_top.
// Assumes one clock and configuration held still while traffic runs.
`timescale 1ns/1ps
module uifc_checker (
  // Clock and reset
  input wire ref_clk_in,
  input wire rst_n_in,
  // Configuration and clears
  input wire auto_cts_en_in,
  input wire auto_rts_en_in,
  input wire [1:0] function_select_in,
  input wire [15:0] baud_divisor_value_in,
  input wire div_x_en_in,
  input wire [3:0] rx_trigger_level_in,
  input wire line_err_clr_in,
  input wire buf_err_clr_in,
  // Pins and status
  input wire cts_n_in,
  input wire txd_out,
  input wire rts_n_out,
  input wire tx_full_out,
  input wire rx_empty_out,
  input wire [7:0] infrared_control_out,
  input wire tx_empty_interrupt_out,
  input wire rx_threshold_interrupt_out,
  input wire line_error_interrupt_out,
  input wire buf_err_interrupt_out
);
  logic [15:0] low_len;
  wire slow = !div_x_en_in && baud_divisor_value_in == 16'h0000 && function_select_in == 2'h0;
  wire ir = function_select_in == 2'h2 && baud_divisor_value_in == 16'h0002;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // Low run length; whole bits only, so a slip in the divider shows here
  always @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      low_len <= 16'h0000;
    else
      low_len <= txd_out ? 16'h0000 : low_len + 16'h0001;
  // Infrared mark of three slots of two clocks
  sequence ir_mark_s;
    txd_out [*6] ##1 !txd_out;
  endsequence
  cts_hold_a: assert property (
    $fell(txd_out) && auto_cts_en_in && function_select_in == 2'h0
    |-> !$past(cts_n_in, 3) || !$past(cts_n_in, 4)) else $error("start while cts high");
  rts_off_a: assert property (
    !auto_rts_en_in && !$past(auto_rts_en_in) && $past(rst_n_in, 2) |-> !rts_n_out)
    else $error("rts released without auto flow");
  ir_rst_a: assert property (!$past(rst_n_in) |-> infrared_control_out == 8'h40)
    else $error("infrared control reset value wrong");
  full_empty_a: assert property (tx_full_out |-> !tx_empty_interrupt_out)
    else $error("tx empty while full");
  ir_pulse_a: assert property ($rose(txd_out) && ir |-> ir_mark_s)
    else $error("infrared pulse width wrong");
  line_sticky_a: assert property (
    line_error_interrupt_out && !line_err_clr_in |=> line_error_interrupt_out)
    else $error("line error dropped without clear");
  buf_clear_a: assert property ($fell(buf_err_interrupt_out) |-> $past(buf_err_clr_in))
    else $error("buffer error dropped without clear");
  rx_thr_a: assert property (
    rx_empty_out && rx_trigger_level_in > 4'h1 |-> !rx_threshold_interrupt_out)
    else $error("threshold with empty fifo");
  bit_len_a: assert property ($rose(txd_out) && slow |-> low_len[4:0] == 5'h00)
    else $error("low run not whole bits");
endmodule
bind uifc_top uifc_checker u_chk (.*);

// file: verif/uifc_peer.sv
// Serial peer: sends 8N1 frames to the controller and decodes its line.
// Assumes the bench sets the bit length; the line idles high.
`timescale 1ns/1ps
module uifc_peer #(
  parameter int BIT = 32
) (
  // Clock
  input wire ref_clk_in,
  // Line from the controller
  input wire txd_in,
  // Line to the controller
  output logic rxd_out
);
  logic [7:0] got_q[$];
  logic [7:0] sh;
  logic listen = 1'b1;
  initial rxd_out = 1'b1;
  // One frame; a low stop bit makes a framing fault on purpose
  task automatic send(input logic [7:0] v, input logic stop_bit);
    logic [9:0] f;
    f = {stop_bit, v, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd_out = f[i];
      repeat (BIT) @(negedge ref_clk_in);
    end
    rxd_out = 1'b1;
  endtask
  // Mid-bit sampling; frames with a low stop bit are not kept
  always @(negedge txd_in)
    if (listen)
    begin
      repeat (BIT / 2) @(posedge ref_clk_in);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT) @(posedge ref_clk_in);
        sh[i] = txd_in;
      end
      repeat (BIT) @(posedge ref_clk_in);
      if (txd_in)
        got_q.push_back(sh);
    end
endmodule

// file: verif/uart_irda_flow_controller_tb_top.sv
// Self-checking bench for uifc_top with a serial peer on the line.
// Assumes the checker binds itself; mode 0 divisor 0 gives 32 clocks a bit.
`timescale 1ns/1ps
module uart_irda_flow_controller_tb_top;
  localparam int BIT = 32;
  logic ref_clk_in = 1'b0, rst_n_in = 1'b0, tx_wr_in = 1'b0, rx_rd_in = 1'b0;
  logic two_stop_in = 1'b0, parity_en_in = 1'b0, div_x_en_in = 1'b0, div_x_one_in = 1'b0;
  logic infrared_control_wr_in = 1'b0, auto_rts_en_in = 1'b0, auto_cts_en_in = 1'b0;
  logic line_err_clr_in = 1'b0, modem_clr_in = 1'b0, buf_err_clr_in = 1'b0, cts_n_in = 1'b1;
  logic [7:0] tx_data_in = 8'h00, infrared_control_in = 8'h40, tx_gap_delay_in = 8'h00;
  logic [1:0] char_len_in = 2'h3, function_select_in = 2'h0;
  logic [2:0] parity_cfg_in = 3'h0;
  logic [15:0] baud_divisor_value_in = 16'h0000;
  logic [3:0] div_x_in = 4'h8, rx_trigger_level_in = 4'h8, rts_deassert_fifo_level_in = 4'h2;
  logic [6:0] rx_timeout_count_in = 7'h04;
  wire rxd_in, rx_empty_out, tx_full_out, txd_out, rts_n_out, tx_empty_interrupt_out;
  wire rx_threshold_interrupt_out, line_error_interrupt_out, rx_idle_timeout_interrupt_out;
  wire modem_interrupt_out, buf_err_interrupt_out;
  wire [7:0] rx_data_out, infrared_control_out;
  wire [2:0] rx_err_out;
  int mismatches = 0, checks = 0, cyc = 0, pulses = 0;
  logic txd_q = 1'b1;
  logic [7:0] exp_q[$];
  logic [7:0] d, r;
  always #4 ref_clk_in = ~ref_clk_in;
  uifc_top u_uifc_top (.*);
  uifc_peer #(.BIT(BIT)) u_uifc_peer (.ref_clk_in(ref_clk_in), .txd_in(txd_out), .rxd_out(rxd_in));
  task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // Gap cycle before each strobe so it is never set twice in one step
  task automatic push(input logic [7:0] v);
    ticks(1);
    tx_data_in = v;
    tx_wr_in = 1'b1;
    ticks(1);
    tx_wr_in = 1'b0;
  endtask
  task automatic pop(input logic [7:0] v, input logic [2:0] e);
    int n = 0;
    while (rx_empty_out !== 1'b0 && n < 2000)
    begin
      ticks(1);
      n++;
    end
    if (n == 2000)
      mismatches++;
    cmp(v, rx_data_out);
    cmp({5'h00, e}, {5'h00, rx_err_out});
    rx_rd_in = 1'b1;
    ticks(1);
    rx_rd_in = 1'b0;
    ticks(3);
  endtask
  task automatic send_rand(input int k, input int keep);
    for (int i = 0; i < k; i++)
    begin
      d = $urandom;
      u_uifc_peer.send(d, 1'b1);
      if (i < keep)
        exp_q.push_back(d);
    end
    ticks(BIT);
  endtask
  task automatic drain;
    foreach (exp_q[i])
      pop(exp_q[i], 3'h0);
    exp_q.delete();
  endtask
  // Cycle ceiling and infrared mark counter
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (txd_out && !txd_q)
      pulses++;
    txd_q = txd_out;
    if (cyc == 40000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial
  begin
    r = $urandom(2);
    ticks(16);
    rst_n_in = 1'b1;
    ticks(2);
    cmp(8'h40, infrared_control_out);
    cmp(8'h07, {5'h00, txd_out, rx_empty_out, tx_empty_interrupt_out});
    cmp(8'h00, {7'h00, modem_interrupt_out});
    $display("test reset done");
    // Hold the far side off, fill the fifo, one write too many
    auto_cts_en_in = 1'b1;
    cts_n_in = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      d = $urandom;
      push(d);
      if (i < 15)
        exp_q.push_back(d);
    end
    ticks(200);
    cmp(8'h02, {6'h00, tx_full_out, tx_empty_interrupt_out});
    cmp(8'h01, {7'h00, txd_out});
    cts_n_in = 1'b0;
    for (int n = 0; n < 8000 && u_uifc_peer.got_q.size() < 15; n++)
      ticks(1);
    ticks(700);
    cmp(8'h0f, 8'(u_uifc_peer.got_q.size()));
    foreach (exp_q[i])
      cmp(exp_q[i], u_uifc_peer.got_q[i]);
    exp_q.delete();
    cmp(8'h01, {7'h00, modem_interrupt_out});
    modem_clr_in = 1'b1;
    ticks(1);
    modem_clr_in = 1'b0;
    ticks(2);
    cmp(8'h00, {7'h00, modem_interrupt_out});
    $display("test tx fifo done");
    // Data left waiting past five bit times raises the idle timeout
    send_rand(3, 3);
    ticks(6 * BIT);
    cmp(8'h01, {7'h00, rx_idle_timeout_interrupt_out});
    drain();
    cmp(8'h00, {7'h00, rx_idle_timeout_interrupt_out});
    u_uifc_peer.send(8'ha5, 1'b0);
    ticks(BIT);
    pop(8'ha5, 3'h2);
    cmp(8'h01, {7'h00, line_error_interrupt_out});
    line_err_clr_in = 1'b1;
    ticks(1);
    line_err_clr_in = 1'b0;
    ticks(2);
    cmp(8'h00, {7'h00, line_error_interrupt_out});
    $display("test rx done");
    auto_rts_en_in = 1'b1;
    ticks(4);
    cmp(8'h00, {7'h00, rts_n_out});
    send_rand(2, 2);
    cmp(8'h01, {7'h00, rts_n_out});
    drain();
    cmp(8'h00, {7'h00, rts_n_out});
    auto_rts_en_in = 1'b0;
    $display("test rts done");
    // Sixteenth character lands on a full fifo
    send_rand(16, 15);
    cmp(8'h01, {7'h00, buf_err_interrupt_out});
    cmp(8'h01, {7'h00, rx_threshold_interrupt_out});
    drain();
    cmp(8'h01, {7'h00, rx_empty_out});
    buf_err_clr_in = 1'b1;
    ticks(1);
    buf_err_clr_in = 1'b0;
    ticks(2);
    cmp(8'h00, {7'h00, buf_err_interrupt_out});
    $display("test overflow done");
    // Transmit only; no infrared reception follows, the turnaround ends inside the run
    function_select_in = 2'h2;
    div_x_en_in = 1'b0;
    baud_divisor_value_in = 16'h0002;
    u_uifc_peer.listen = 1'b0;
    ticks(64);
    pulses = 0;
    d = $urandom;
    push(d);
    ticks(12 * BIT);
    cmp(8'(9 - $countones(d)), 8'(pulses));
    $display("test infrared done");
    tally_and_finish();
  end
endmodule
